// File: core/flash_host_pkg.sv
// constants shared by the flash host controller and its pin sequencer
// assumes a 200 MHz aclk and a 16-bit parallel flash on the far side
// How it works
// RL1 - upper address bits pick an eight-word page, low three pick the word
// RL2 - same page, select held: later words use the short page latency
// RL3 - after select is released, next access uses full initial latency
// RL4 - word index inside a page is the binary of address bits 2..0
// RL5 - flash drives data only with select and output enable both low
// RL6 - after power-up plain reads return array data, no command needed
// RL7 - a bank goes back to array read after program or erase ends
// RL8 - flash latches address at the later falling edge of strobe/select
// RL9 - flash latches data at the earlier rising edge of strobe/select
// RL10 - erase suspend lets reads of unsuspended sectors in that bank
// RL11 - reads inside an erase-suspended sector return status
// RL12 - after program during erase suspend, same read rules apply again
// RL13 - program suspend lets reads of unsuspended sectors in that bank
// RL14 - identifier entry: AA at 555, 55 at 2AA, 90 at 555 in bank
// RL15 - F0 at any address leaves identifier mode
// RL16 - bank bits on third entry write put only that bank in id mode
// RL17 - enter id mode only when no other bank programs or erases
// RL18 - id mode needs no page reads or read-while-write
// RL19 - id low addresses 0,1,E,F give maker and part codes
// RL20 - id low address 2 with sector bits gives protection state
// RL21 - id low address 3 gives lock and handshake indicator bits
// RL22 - other address bits are ignored during identifier reads
// RL23 - after a bad command sequence write reset to restore array read

package flash_host_pkg;
   localparam int ADDR_W = 24;
   localparam int DATA_W = 16;
   localparam int PAGE_LSB = 3;
   // register byte offsets
   localparam logic [7:0] REG_ADDR = 8'h00;
   localparam logic [7:0] REG_WDATA = 8'h04;
   localparam logic [7:0] REG_CMD = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_RDATA = 8'h10;
   // command field codes in REG_CMD[2:0]
   localparam logic [2:0] CMD_READ = 3'h1;
   localparam logic [2:0] CMD_WRITE = 3'h2;
   localparam logic [2:0] CMD_ID_ENTER = 3'h3;
   localparam logic [2:0] CMD_ID_EXIT = 3'h4;
   // command sequence words
   localparam logic [11:0] UNLOCK1_OFS = 12'h555;
   localparam logic [11:0] UNLOCK2_OFS = 12'h2AA;
   localparam logic [15:0] UNLOCK1_DATA = 16'h00AA;
   localparam logic [15:0] UNLOCK2_DATA = 16'h0055;
   localparam logic [15:0] ID_ENTER_DATA = 16'h0090;
   localparam logic [15:0] ID_EXIT_DATA = 16'h00F0;
   localparam int BANK_BITS = 4;
   // timing in ns and derived cycles at 5 ns
   localparam int CLK_NS = 5;
   localparam int T_INIT_NS = 70;
   localparam int T_PAGE_NS = 25;
   localparam int T_WP_NS = 40;
   localparam int T_REC_NS = 20;
   // two sync stages plus one cycle: sampling right at the limit races
   localparam int INIT_CYC = (T_INIT_NS + CLK_NS - 1) / CLK_NS + 3;
   localparam int PAGE_CYC = (T_PAGE_NS + CLK_NS - 1) / CLK_NS + 3;
   localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int REC_CYC = (T_REC_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 6;
endpackage : flash_host_pkg

// File: core/flash_pin_seq.sv
// one flash bus cycle (read or write) on the parallel pins
// assumes inputs from the controller on aclk; dq_in from pins, resynced
`timescale 1ns/1ps
module flash_pin_seq (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // request
   input wire logic req,
   input wire logic req_write,
   input wire logic req_hold,
   input wire logic [23:0] req_addr,
   input wire logic [15:0] req_wdata,
   output logic done,
   output logic [15:0] rdata,
   // pins
   output logic ce_n,
   output logic oe_n,
   output logic we_n,
   output logic [23:0] addr,
   input wire logic [15:0] dq_in,
   output logic [15:0] dq_out,
   output logic dq_oe
);
   typedef enum logic [2:0] {S_IDLE, S_RD, S_WSET, S_WHOLD, S_REC} st_t;
   st_t st_r, st_nxt;
   logic [5:0] cnt_r, cnt_nxt;
   logic [15:0] dq_s1_r, dq_s2_r;
   logic page_ok_r, page_ok_nxt;
   logic [20:0] page_r, page_nxt;
   logic done_nxt, ce_n_nxt, oe_n_nxt, we_n_nxt, dq_oe_nxt;
   logic [23:0] addr_nxt;
   logic [15:0] dq_out_nxt, rdata_nxt;

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      page_ok_nxt = page_ok_r;
      page_nxt = page_r;
      done_nxt = 1'b0;
      ce_n_nxt = ce_n;
      oe_n_nxt = oe_n;
      we_n_nxt = we_n;
      addr_nxt = addr;
      dq_out_nxt = dq_out;
      dq_oe_nxt = dq_oe;
      rdata_nxt = rdata;
      unique case (st_r)
         S_IDLE: if (req) begin
            addr_nxt = req_addr;
            ce_n_nxt = 1'b0;
            if (req_write) begin
               // strobe low after select: address taken at strobe fall
               dq_out_nxt = req_wdata;
               dq_oe_nxt = 1'b1;
               oe_n_nxt = 1'b1;
               cnt_nxt = 6'(flash_host_pkg::WP_CYC);
               page_ok_nxt = 1'b0;
               st_nxt = S_WSET; // RL8
            end else begin
               oe_n_nxt = 1'b0; // RL5
               // same page while select held: short wait
               if (page_ok_r && !ce_n && page_r ==
                   req_addr[23:flash_host_pkg::PAGE_LSB])
                  cnt_nxt = 6'(flash_host_pkg::PAGE_CYC); // RL2 RL4
               else
                  cnt_nxt = 6'(flash_host_pkg::INIT_CYC); // RL3 RL1
               page_nxt = req_addr[23:flash_host_pkg::PAGE_LSB]; // RL1
               st_nxt = S_RD;
            end
         end else if (!req_hold) begin
            ce_n_nxt = 1'b1;
            oe_n_nxt = 1'b1;
            page_ok_nxt = 1'b0; // RL3
         end
         S_RD: if (cnt_r == 6'h00) begin
            // two sync stages add latency; counted in the cycle figure
            rdata_nxt = dq_s2_r;
            done_nxt = 1'b1;
            page_ok_nxt = 1'b1;
            st_nxt = S_IDLE;
         end else
            cnt_nxt = cnt_r - 6'h01;
         S_WSET: begin
            we_n_nxt = 1'b0;
            st_nxt = S_WHOLD;
         end
         S_WHOLD: if (cnt_r == 6'h00) begin
            we_n_nxt = 1'b1; // RL9
            cnt_nxt = 6'(flash_host_pkg::REC_CYC);
            st_nxt = S_REC;
         end else
            cnt_nxt = cnt_r - 6'h01;
         S_REC: if (cnt_r == 6'h00) begin
            dq_oe_nxt = 1'b0;
            ce_n_nxt = 1'b1;
            done_nxt = 1'b1;
            st_nxt = S_IDLE;
         end else
            cnt_nxt = cnt_r - 6'h01;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= S_IDLE;
         cnt_r <= 6'h00;
         page_ok_r <= 1'b0;
         page_r <= 21'h000000;
         done <= 1'b0;
         ce_n <= 1'b1;
         oe_n <= 1'b1;
         we_n <= 1'b1;
         addr <= 24'h000000;
         dq_out <= 16'h0000;
         dq_oe <= 1'b0;
         rdata <= 16'h0000;
         dq_s1_r <= 16'h0000;
         dq_s2_r <= 16'h0000;
      end else if (ce) begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         page_ok_r <= page_ok_nxt;
         page_r <= page_nxt;
         done <= done_nxt;
         ce_n <= ce_n_nxt;
         oe_n <= oe_n_nxt;
         we_n <= we_n_nxt;
         addr <= addr_nxt;
         dq_out <= dq_out_nxt;
         dq_oe <= dq_oe_nxt;
         rdata <= rdata_nxt;
         dq_s1_r <= dq_in;
         dq_s2_r <= dq_s1_r;
      end
   end
endmodule : flash_pin_seq

// File: core/flash_host.sv
// host-side flash controller: AXI4-Lite registers to flash pin cycles
// assumes one aclk domain; flash pins asynchronous, data resynced
`timescale 1ns/1ps
module flash_host (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic clk_en,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // flash pins
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   output logic [23:0] flash_addr,
   input wire logic [15:0] flash_dq_in,
   output logic [15:0] flash_dq_out,
   output logic flash_dq_oe
);
   typedef enum logic [2:0] {C_IDLE, C_ONE, C_SEQ1, C_SEQ2, C_SEQ3}
      cst_t;
   cst_t cst_r, cst_nxt;
   logic [23:0] addr_r, addr_nxt;
   logic [15:0] wdata_r, wdata_nxt;
   logic hold_r, hold_nxt;
   logic busy_r, busy_nxt;
   logic idmode_r, idmode_nxt;
   logic bad_r, bad_nxt;
   logic req_r, req_nxt, rw_r, rw_nxt;
   logic [23:0] raddr_r, raddr_nxt;
   logic [15:0] rwd_r, rwd_nxt;
   logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt;
   logic [7:0] awa_r, awa_nxt;
   logic [31:0] wd_r, wd_nxt;
   logic bvalid_nxt, rvalid_nxt;
   logic [1:0] bresp_nxt, rresp_nxt;
   logic [31:0] rdata_nxt;
   logic seq_done;
   logic [15:0] seq_rdata;

   // bank-relative command address: bank bits kept, offset replaced
   function automatic logic [23:0] cmd_addr(input logic [23:0] a,
                                            input logic [11:0] ofs);
      cmd_addr = {a[23:20], 8'h00, ofs};
   endfunction : cmd_addr

   flash_pin_seq u_seq (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(clk_en),
      .req(req_r),
      .req_write(rw_r),
      .req_hold(hold_r),
      .req_addr(raddr_r),
      .req_wdata(rwd_r),
      .done(seq_done),
      .rdata(seq_rdata),
      .ce_n(flash_ce_n),
      .oe_n(flash_oe_n),
      .we_n(flash_we_n),
      .addr(flash_addr),
      .dq_in(flash_dq_in),
      .dq_out(flash_dq_out),
      .dq_oe(flash_dq_oe)
   );

   ////////////////////////////////////////////////////////////////////
   // register slave and command sequencer
   always_comb begin
      cst_nxt = cst_r;
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      hold_nxt = hold_r;
      busy_nxt = busy_r;
      idmode_nxt = idmode_r;
      bad_nxt = bad_r;
      req_nxt = 1'b0;
      rw_nxt = rw_r;
      raddr_nxt = raddr_r;
      rwd_nxt = rwd_r;
      aw_ok_nxt = aw_ok_r;
      w_ok_nxt = w_ok_r;
      awa_nxt = awa_r;
      wd_nxt = wd_r;
      bvalid_nxt = s_axi_bvalid;
      bresp_nxt = s_axi_bresp;
      rvalid_nxt = s_axi_rvalid;
      rresp_nxt = s_axi_rresp;
      rdata_nxt = s_axi_rdata;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_ok_nxt = 1'b1;
         awa_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_ok_nxt = 1'b1;
         wd_nxt = s_axi_wdata;
      end
      if (s_axi_bvalid && s_axi_bready)
         bvalid_nxt = 1'b0;
      if (s_axi_rvalid && s_axi_rready)
         rvalid_nxt = 1'b0;
      // write completes once both halves are held
      if (aw_ok_r && w_ok_r && !s_axi_bvalid) begin
         aw_ok_nxt = 1'b0;
         w_ok_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = 2'b00;
         unique case (awa_r)
            flash_host_pkg::REG_ADDR: addr_nxt = wd_r[23:0];
            flash_host_pkg::REG_WDATA: wdata_nxt = wd_r[15:0];
            flash_host_pkg::REG_CMD:
               if (busy_r) bresp_nxt = 2'b10; // RL17
               else begin
                  hold_nxt = wd_r[8];
                  bad_nxt = 1'b0;
                  unique case (wd_r[2:0])
                     flash_host_pkg::CMD_READ: begin
                        req_nxt = 1'b1;
                        rw_nxt = 1'b0;
                        raddr_nxt = addr_r;
                        busy_nxt = 1'b1;
                        cst_nxt = C_ONE;
                     end
                     flash_host_pkg::CMD_WRITE: begin
                        req_nxt = 1'b1;
                        rw_nxt = 1'b1;
                        raddr_nxt = addr_r;
                        rwd_nxt = wdata_r;
                        busy_nxt = 1'b1;
                        cst_nxt = C_ONE;
                     end
                     flash_host_pkg::CMD_ID_ENTER: begin
                        req_nxt = 1'b1;
                        rw_nxt = 1'b1;
                        raddr_nxt = cmd_addr(addr_r,
                           flash_host_pkg::UNLOCK1_OFS); // RL14 RL16
                        rwd_nxt = flash_host_pkg::UNLOCK1_DATA;
                        busy_nxt = 1'b1;
                        cst_nxt = C_SEQ1;
                     end
                     flash_host_pkg::CMD_ID_EXIT: begin
                        req_nxt = 1'b1;
                        rw_nxt = 1'b1;
                        raddr_nxt = addr_r;
                        rwd_nxt = flash_host_pkg::ID_EXIT_DATA; // RL15 RL23
                        busy_nxt = 1'b1;
                        idmode_nxt = 1'b0;
                        cst_nxt = C_ONE;
                     end
                     default: bad_nxt = 1'b1;
                  endcase
               end
            default: bresp_nxt = 2'b10;
         endcase
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = 2'b00;
         unique case (s_axi_araddr)
            flash_host_pkg::REG_ADDR: rdata_nxt = {8'h00, addr_r};
            flash_host_pkg::REG_WDATA: rdata_nxt = {16'h0000, wdata_r};
            flash_host_pkg::REG_CMD: rdata_nxt = {23'h000000, hold_r,
                                                  8'h00};
            flash_host_pkg::REG_STATUS: rdata_nxt = {29'h00000000, bad_r,
                                                     idmode_r, busy_r};
            flash_host_pkg::REG_RDATA: rdata_nxt = {16'h0000, seq_rdata};
            default: begin
               rdata_nxt = 32'h00000000;
               rresp_nxt = 2'b10;
            end
         endcase
      end
      if (seq_done) begin
         unique case (cst_r)
            C_SEQ1: begin
               req_nxt = 1'b1;
               raddr_nxt = cmd_addr(addr_r, flash_host_pkg::UNLOCK2_OFS);
               rwd_nxt = flash_host_pkg::UNLOCK2_DATA; // RL14
               cst_nxt = C_SEQ2;
            end
            C_SEQ2: begin
               req_nxt = 1'b1;
               raddr_nxt = cmd_addr(addr_r, flash_host_pkg::UNLOCK1_OFS);
               rwd_nxt = flash_host_pkg::ID_ENTER_DATA; // RL14
               cst_nxt = C_SEQ3;
            end
            C_SEQ3: begin
               idmode_nxt = 1'b1;
               busy_nxt = 1'b0;
               cst_nxt = C_IDLE;
            end
            default: begin
               busy_nxt = 1'b0;
               cst_nxt = C_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cst_r <= C_IDLE;
         addr_r <= 24'h000000;
         wdata_r <= 16'h0000;
         hold_r <= 1'b0;
         busy_r <= 1'b0;
         idmode_r <= 1'b0; // RL6
         bad_r <= 1'b0;
         req_r <= 1'b0;
         rw_r <= 1'b0;
         raddr_r <= 24'h000000;
         rwd_r <= 16'h0000;
         aw_ok_r <= 1'b0;
         w_ok_r <= 1'b0;
         awa_r <= 8'h00;
         wd_r <= 32'h00000000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp <= 2'b00;
         s_axi_rdata <= 32'h00000000;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_arready <= 1'b0;
      end else if (clk_en) begin
         cst_r <= cst_nxt;
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         hold_r <= hold_nxt;
         busy_r <= busy_nxt;
         idmode_r <= idmode_nxt;
         bad_r <= bad_nxt;
         req_r <= req_nxt;
         rw_r <= rw_nxt;
         raddr_r <= raddr_nxt;
         rwd_r <= rwd_nxt;
         aw_ok_r <= aw_ok_nxt;
         w_ok_r <= w_ok_nxt;
         awa_r <= awa_nxt;
         wd_r <= wd_nxt;
         s_axi_bvalid <= bvalid_nxt;
         s_axi_bresp <= bresp_nxt;
         s_axi_rvalid <= rvalid_nxt;
         s_axi_rresp <= rresp_nxt;
         s_axi_rdata <= rdata_nxt;
         // ready only while the matching half is not yet held, arready only while no read answer is pending
         s_axi_awready <= !aw_ok_nxt && !s_axi_awready;
         s_axi_wready <= !w_ok_nxt && !s_axi_wready;
         s_axi_arready <= !rvalid_nxt && !s_axi_arready;
      end
   end
endmodule : flash_host

// File: testbench/flash_host_props.sv
// checker: flash pin cycles and bus answer timing of the host
// assumes bind into flash_host; one aclk domain
`timescale 1ns/1ps
module flash_host_props (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // bus
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   // pins
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic [23:0] flash_addr,
   input wire logic [15:0] flash_dq_out,
   input wire logic flash_dq_oe
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////
   a_oe_selected: assert property (
      !flash_oe_n |-> !flash_ce_n)
      else $error("output enable without select");
   a_no_fight: assert property (
      !flash_oe_n |-> !flash_dq_oe && flash_we_n)
      else $error("host drives data in a read");
   a_we_framed: assert property (
      !flash_we_n |-> !flash_ce_n && flash_dq_oe && flash_oe_n)
      else $error("strobe low without select or data");
   a_wr_stable: assert property (
      !flash_we_n && !$past(flash_we_n)
      |-> $stable(flash_addr) && $stable(flash_dq_out))
      else $error("address or data moved under strobe");
   a_we_width: assert property (
      $fell(flash_we_n) |-> (!flash_we_n)[*8])
      else $error("write strobe too short");
   a_data_last: assert property (
      $rose(flash_we_n) |-> flash_dq_oe && !flash_ce_n)
      else $error("data or select gone before strobe rise");
   a_rd_hold: assert property (
      $fell(flash_oe_n) |=> (!flash_oe_n && $stable(flash_addr))[*4])
      else $error("read address not held");
   a_r_next: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_b_bound: assert property (
      s_axi_awvalid && s_axi_awready |-> ##[1:6] s_axi_bvalid)
      else $error("write answer late");
endmodule : flash_host_props

// File: testbench/flash_dev_model.sv
// behavioural parallel flash: array reads, page timing, identifier mode
// assumes host pins from flash_host; no clock, times in ns
`timescale 1ns/1ps
module flash_dev_model #(
   parameter int T_INIT = flash_host_pkg::T_INIT_NS,
   parameter int T_PAGE = flash_host_pkg::T_PAGE_NS,
   // identity words: arbitrary values
   parameter logic [15:0] MAKER = 16'h0A51,
   parameter logic [15:0] PART1 = 16'h1B62,
   parameter logic [15:0] PART2 = 16'h2C73,
   parameter logic [15:0] PART3 = 16'h3D84,
   parameter logic [2:0] IND_BITS = 3'h5,
   // suspend, resume and status words: arbitrary values
   parameter logic [15:0] SUSP_CMD = 16'h0077,
   parameter logic [15:0] RESUME_CMD = 16'h0066,
   parameter logic [15:0] SUSP_STAT = 16'h0044
) (
   // pins
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic [23:0] flash_addr,
   input wire logic [15:0] flash_dq_out,
   input wire logic flash_dq_oe,
   output logic [15:0] flash_dq_in
);
   logic [20:0] page_q = '0;
   logic ce_q = 1'b1;
   logic id_on = 1'b0;
   logic armed = 1'b0;
   logic [3:0] id_bank = '0;
   logic [1:0] step = '0;
   logic esus = 1'b0;
   logic [6:0] esec = '0;
   logic [23:0] wa = '0;
   logic [15:0] wd;
   realtime t_ok = 0;
   wire logic wstb_n = flash_we_n | flash_ce_n;
   ////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] word_at(input logic [23:0] a);
      if (step == 2'd3)
         return ~a[15:0];
      if (esus && a[23:17] == esec)
         return SUSP_STAT;
      if (id_on && a[23:20] == id_bank) begin
         case (a[3:0])
            4'h0: return MAKER;
            4'h1: return PART1;
            4'hE: return PART2;
            4'hF: return PART3;
            4'h2: return {15'h0, a[17]};
            4'h3: return {8'h00, IND_BITS, 5'h00};
            default: return 16'h0000;
         endcase
      end
      return a[15:0] ^ a[23:8];
   endfunction : word_at
   // no page hits in id mode, select drop restarts
   always @(flash_addr or flash_ce_n) begin
      t_ok = $realtime + ((!ce_q && !flash_ce_n && !id_on
         && page_q == flash_addr[23:3]) ? T_PAGE : T_INIT);
      ce_q = flash_ce_n;
      page_q = flash_addr[23:3];
   end
   // no pull on the bus: garbage whenever not driving
   always #1 begin
      if (!flash_ce_n && !flash_oe_n && $realtime >= t_ok)
         flash_dq_in = word_at(flash_addr);
      else
         flash_dq_in = ~flash_dq_in;
   end
   always @(negedge wstb_n) begin
      wa = flash_addr;
      armed = 1'b1;
   end
   always @(posedge wstb_n) begin
      if (armed) begin
         armed = 1'b0;
         wd = flash_dq_oe ? flash_dq_out : ~flash_dq_out;
         if (wd == 16'h00F0) begin
            id_on = 1'b0;
            step = 2'd0;
         end else if (wd == SUSP_CMD) begin
            esus = 1'b1;
            esec = wa[23:17];
         end else if (wd == RESUME_CMD)
            esus = 1'b0;
         else if (step == 2'd0 && wa[19:0] == 20'h00555
               && wd == 16'h00AA)
            step = 2'd1;
         else if (step == 2'd1 && wa[19:0] == 20'h002AA
               && wd == 16'h0055)
            step = 2'd2;
         else if (step == 2'd2 && wa[19:0] == 20'h00555
               && wd == 16'h0090) begin
            id_on = 1'b1;
            id_bank = wa[23:20];
            step = 2'd0;
         end else
            step = 2'd3;
      end
   end
   initial flash_dq_in = 16'h0F0F;
endmodule : flash_dev_model

// File: testbench/flash_host_test.sv
// bench: register tasks on the bus, flash model on the pins
// assumes flash_host, flash_dev_model and the checker; 200 MHz aclk
`timescale 1ns/1ps
module flash_host_test;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic awready, wready, bvalid, arready, rvalid, ce_n, oe_n, we_n;
   logic dq_oe;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rdata, val;
   logic [23:0] faddr;
   logic [15:0] dq_in, dq_out;
   logic [23:0] ida[5] = '{24'h23A530, 24'h2FF531, 24'h20053E,
      24'h23A532, 24'h21A533};
   logic [15:0] idv[5];
   int fail_count = 0;
   int total_checks = 0;
   flash_host DUT (.aclk(aclk), .aresetn(aresetn), .clk_en(1'b1),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
      .flash_addr(faddr), .flash_dq_in(dq_in), .flash_dq_out(dq_out),
      .flash_dq_oe(dq_oe));
   flash_dev_model mem (.flash_ce_n(ce_n), .flash_oe_n(oe_n),
      .flash_we_n(we_n), .flash_addr(faddr), .flash_dq_out(dq_out),
      .flash_dq_oe(dq_oe), .flash_dq_in(dq_in));
   ////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      if (fail_count == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (awvalid || wvalid);
      bready <= 1'b1;
      do @(posedge aclk); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      rready <= 1'b1;
      do @(posedge aclk); while (rvalid !== 1'b1);
      val = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask : rd
   task automatic poll;
      do rd(flash_host_pkg::REG_STATUS); while (val[0] !== 1'b0);
   endtask : poll
   task automatic op(input logic [23:0] a, input logic [15:0] d,
         input logic [8:0] cmd);
      wr(flash_host_pkg::REG_ADDR, {8'h00, a});
      wr(flash_host_pkg::REG_WDATA, {16'h0000, d});
      wr(flash_host_pkg::REG_CMD, {23'h0, cmd});
      poll();
   endtask : op
   task automatic fread(input logic [23:0] a, input logic hold);
      op(a, 16'h0000, {hold, 5'h00, flash_host_pkg::CMD_READ});
      rd(flash_host_pkg::REG_RDATA);
   endtask : fread
   // array contents as the model lays them out
   function automatic logic [31:0] arr(input logic [23:0] a);
      return {16'h0000, a[15:0] ^ a[23:8]};
   endfunction : arr
   ////////////////////////////////////////////////////////////////////
   initial forever #2.5 aclk = ~aclk;
   // whole run is under two thousand cycles; this is far beyond it
   initial begin
      #400000;
      fail_count++;
      report_and_stop();
   end
   initial begin
      idv = '{mem.MAKER, mem.PART1, mem.PART2, 16'h0001,
         {8'h00, mem.IND_BITS, 5'h00}};
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      for (int i = 0; i < 8; i++) begin
         fread(24'h012347 - 24'(i), 1'b1);
         chk(val, arr(24'h012347 - 24'(i)));
      end
      fread(24'h012345, 1'b0);
      fread(24'h012346, 1'b0);
      chk(val, arr(24'h012346));
      fread(24'hFFFFFF, 1'b1);
      chk(val, arr(24'hFFFFFF));
      rd(flash_host_pkg::REG_CMD);
      chk(val, 32'h00000100);
      rd(flash_host_pkg::REG_ADDR);
      chk(val, 32'h00FFFFFF);
      rd(8'h1C);
      chk({30'h0, resp}, 32'h2);
      chk(val, 32'h0);
      wr(8'h1C, 32'h1);
      chk({30'h0, resp}, 32'h2);
      wr(flash_host_pkg::REG_CMD, 32'h1);
      wr(flash_host_pkg::REG_CMD, 32'h1);
      chk({30'h0, resp}, 32'h2);
      poll();
      wr(flash_host_pkg::REG_CMD, 32'h7);
      rd(flash_host_pkg::REG_STATUS);
      chk({31'h0, val[2]}, 32'h1);
      op(24'h200000, 16'h0000, 9'h3);
      chk({31'h0, val[1]}, 32'h1);
      for (int i = 0; i < 5; i++) begin
         fread(ida[i], 1'b0);
         chk(val, {16'h0000, idv[i]});
      end
      fread(24'h312345, 1'b0);
      chk(val, arr(24'h312345));
      op(24'hABCDEF, 16'h0000, 9'h4);
      fread(24'h23A530, 1'b0);
      chk(val, arr(24'h23A530));
      op(24'h300555, 16'h00AA, 9'h2);
      op(24'h3002AA, 16'h0055, 9'h2);
      op(24'h300555, 16'h0090, 9'h2);
      fread(24'h300000, 1'b0);
      chk(val, {16'h0000, mem.MAKER});
      op(24'h300556, 16'h00AA, 9'h2);
      op(24'h5A5A5A, 16'h00F0, 9'h2);
      fread(24'h300000, 1'b0);
      chk(val, arr(24'h300000));
      op(24'h340000, mem.SUSP_CMD, 9'h2);
      fread(24'h340001, 1'b0);
      chk(val, {16'h0000, mem.SUSP_STAT});
      fread(24'h360001, 1'b0);
      chk(val, arr(24'h360001));
      op(24'h340000, mem.RESUME_CMD, 9'h2);
      fread(24'h340001, 1'b0);
      chk(val, arr(24'h340001));
      report_and_stop();
   end
endmodule : flash_host_test
bind flash_host flash_host_props chk_i (.aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n),
   .flash_we_n(flash_we_n), .flash_addr(flash_addr),
   .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe));
